// *** shared/cmp_ctrl_consts.vh ***
// Purpose: constants for the analog comparator control block
// Assumes: one clock, synchronous active-high reset
// Notes:   field codes match the control ports of the block
`ifndef CMP_CTRL_CONSTS_VH
`define CMP_CTRL_CONSTS_VH

`define INCFG_DIRECT      2'h0
`define INCFG_GND_NEG     2'h1
`define INCFG_DAC_POS     2'h2
`define INCFG_DAC_NEG     2'h3

`define HYST_OFF          2'h0
`define HYST_MAX          2'h3

`define RESP_RESET        2'h2
`define MUX_RESET         4'hf
`define DAC_LEVEL_RESET   6'h00

`define CH_INTERNAL       4'h8
`define CH_SUPPLY         4'hf
`define CMP0_LAST_PIN     4'ha
`define CMP1_LAST_PIN     4'hc

// analog routing selector codes for a comparator input
`define ROUTE_NONE        3'h0
`define ROUTE_PIN         3'h1
`define ROUTE_REGULATOR   3'h2
`define ROUTE_GROUND      3'h3
`define ROUTE_SUPPLY      3'h4
`define ROUTE_DAC         3'h5

`endif

// *** verilog/cmp_channel.v ***
// Purpose: digital control for one comparator channel
// Assumes: analog result arrives asynchronously on i_raw
// Notes:   last pin code differs between comparators, hence a parameter
`timescale 1ns/1ps
`include "cmp_ctrl_consts.vh"

module cmp_channel #(
    parameter [3:0] LAST_PIN = `CMP0_LAST_PIN
) (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_raw,
    input  wire       i_enable,
    input  wire       i_invert,
    input  wire       i_hold_en,
    input  wire       i_hold_ch,
    input  wire       i_rise_clr,
    input  wire       i_fall_clr,
    input  wire       i_rise_mask,
    input  wire       i_fall_mask,
    input  wire [1:0] i_input_config,
    input  wire [3:0] i_pos_sel,
    input  wire [3:0] i_neg_sel,
    input  wire [1:0] i_response,
    input  wire [1:0] i_pos_hyst,
    input  wire [1:0] i_neg_hyst,
    input  wire [5:0] i_dac_level,
    output reg  [2:0] o_pos_route,
    output reg  [2:0] o_neg_route,
    output reg  [3:0] o_pos_pin,
    output reg  [3:0] o_neg_pin,
    output reg  [2:0] o_dac_ref_route,
    output reg  [3:0] o_dac_ref_pin,
    output reg  [5:0] o_dac_level,
    output reg        o_dac_on,
    output reg        o_power,
    output reg  [1:0] o_response,
    output reg  [1:0] o_pos_hyst,
    output reg  [1:0] o_neg_hyst,
    output wire       o_async,
    output reg        o_sync,
    output reg        o_state,
    output reg        o_rise_flag,
    output reg        o_fall_flag,
    output wire       o_irq
);

    // ****************************************************************
    // channel decode
    // ****************************************************************
    // maps a select code to a route class; pos side uses the regulator
    function [2:0] decode_route;
        input [3:0] code;
        input       is_pos;
        begin
            if (code < `CH_INTERNAL) begin
                decode_route = `ROUTE_PIN;
            end else if (code == `CH_INTERNAL) begin
                decode_route = is_pos ? `ROUTE_REGULATOR : `ROUTE_GROUND;
            end else if (code == `CH_SUPPLY) begin
                decode_route = `ROUTE_SUPPLY;
            end else if (code <= LAST_PIN) begin
                decode_route = `ROUTE_PIN;
            end else begin
                decode_route = `ROUTE_NONE;
            end
        end
    endfunction

    wire [2:0] pos_ch = decode_route(i_pos_sel, 1'b1);
    wire [2:0] neg_ch = decode_route(i_neg_sel, 1'b0);

    reg [2:0] pos_route_d;
    reg [2:0] neg_route_d;
    reg [2:0] ref_route_d;
    reg [3:0] ref_pin_d;
    reg       dac_on_d;

    always @* begin
        pos_route_d = pos_ch;
        neg_route_d = neg_ch;
        ref_route_d = `ROUTE_NONE;
        ref_pin_d   = 4'h0;
        dac_on_d    = 1'b0;
        case (i_input_config)
            `INCFG_DIRECT: begin
                pos_route_d = pos_ch;
            end
            `INCFG_GND_NEG: begin
                neg_route_d = `ROUTE_GROUND;
            end
            `INCFG_DAC_POS: begin
                pos_route_d = `ROUTE_DAC;
                ref_route_d = pos_ch;
                ref_pin_d   = i_pos_sel;
                dac_on_d    = 1'b1;
            end
            default: begin
                neg_route_d = `ROUTE_DAC;
                ref_route_d = neg_ch;
                ref_pin_d   = i_neg_sel;
                dac_on_d    = 1'b1;
            end
        endcase
    end

    // registered analog controls; power follows enable
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pos_route     <= `ROUTE_NONE;
            o_neg_route     <= `ROUTE_NONE;
            o_pos_pin       <= `MUX_RESET;
            o_neg_pin       <= `MUX_RESET;
            o_dac_ref_route <= `ROUTE_NONE;
            o_dac_ref_pin   <= 4'h0;
            o_dac_level     <= `DAC_LEVEL_RESET;
            o_dac_on        <= 1'b0;
            o_power         <= 1'b0;
            o_response      <= `RESP_RESET;
            o_pos_hyst      <= `HYST_OFF;
            o_neg_hyst      <= `HYST_OFF;
        end else begin
            o_pos_route     <= pos_route_d;
            o_neg_route     <= neg_route_d;
            o_pos_pin       <= i_pos_sel;
            o_neg_pin       <= i_neg_sel;
            o_dac_ref_route <= ref_route_d;
            o_dac_ref_pin   <= ref_pin_d;
            o_dac_level     <= i_dac_level;
            o_dac_on        <= dac_on_d & i_enable;
            o_power         <= i_enable;
            o_response      <= i_response;
            o_pos_hyst      <= i_pos_hyst;
            o_neg_hyst      <= i_neg_hyst;
        end
    end

    // ****************************************************************
    // output path
    // ****************************************************************
    // inhibit holds the last result after optional inversion while the channel is low
    reg  held_q;
    wire polar     = i_raw ^ i_invert;
    wire hold_now  = i_hold_en & ~i_hold_ch;
    wire cmp_out   = hold_now ? held_q : polar;

    always @(posedge i_clk) begin
        if (i_rst) begin
            held_q <= 1'b0;
        end else if (!hold_now) begin
            held_q <= polar;
        end
    end

    // disabled comparator shows low on routed pins
    assign o_async = i_enable & cmp_out;

    // three stages; a change counts once stages two and three agree
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= o_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    wire agree = (s2_q == s3_q);
    wire rise  = agree & s3_q & ~o_state;
    wire fall  = agree & ~s3_q & o_state;

    // ****************************************************************
    // state and edge flags
    // ****************************************************************
    // set beats a clear arriving in the same cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_state     <= 1'b0;
            o_sync      <= 1'b0;
            o_rise_flag <= 1'b0;
            o_fall_flag <= 1'b0;
        end else begin
            if (agree) begin
                o_state <= s3_q;
            end
            o_sync <= agree ? s3_q : o_state;
            if (rise) begin
                o_rise_flag <= 1'b1;
            end else if (i_rise_clr) begin
                o_rise_flag <= 1'b0;
            end
            if (fall) begin
                o_fall_flag <= 1'b1;
            end else if (i_fall_clr) begin
                o_fall_flag <= 1'b0;
            end
        end
    end

    assign o_irq = (o_rise_flag & i_rise_mask) | (o_fall_flag & i_fall_mask);

endmodule

// *** verilog/analog_comparator_control.v ***
// Purpose: control and output logic around two analog comparators
// Assumes: analog results on I_RAW are asynchronous; software drives the
//          control ports and pulses the clear inputs
// Notes:   software should clear both flags after enabling or mode
//          changes, before unmasking; the block cannot tell false edges
`timescale 1ns/1ps
`include "cmp_ctrl_consts.vh"

module analog_comparator_control (
    input  wire        I_CLK,
    input  wire        I_RST,
    input  wire [1:0]  I_RAW,
    input  wire [1:0]  I_CMP_ENABLE,
    input  wire [1:0]  I_OUTPUT_INVERT,
    input  wire [1:0]  I_OUTPUT_HOLD_ENABLE,
    input  wire        I_HOLD_CONTROL_CHANNEL,
    input  wire [1:0]  I_RISING_FLAG_CLR,
    input  wire [1:0]  I_FALLING_FLAG_CLR,
    input  wire [1:0]  I_RISING_IRQ_MASK,
    input  wire [1:0]  I_FALLING_IRQ_MASK,
    input  wire [3:0]  I_INPUT_CONFIG,
    input  wire [7:0]  I_POS_CHANNEL_SELECT,
    input  wire [7:0]  I_NEG_CHANNEL_SELECT,
    input  wire [3:0]  I_RESPONSE_SELECT,
    input  wire [3:0]  I_POS_HYSTERESIS_SELECT,
    input  wire [3:0]  I_NEG_HYSTERESIS_SELECT,
    input  wire [11:0] I_DAC_LEVEL,
    output wire [5:0]  O_POS_ROUTE,
    output wire [5:0]  O_NEG_ROUTE,
    output wire [7:0]  O_POS_PIN,
    output wire [7:0]  O_NEG_PIN,
    output wire [5:0]  O_DAC_REF_ROUTE,
    output wire [7:0]  O_DAC_REF_PIN,
    output wire [11:0] O_DAC_LEVEL,
    output wire [1:0]  O_DAC_ON,
    output wire [1:0]  O_POWER,
    output wire [3:0]  O_RESPONSE,
    output wire [3:0]  O_POS_HYST,
    output wire [3:0]  O_NEG_HYST,
    output wire [1:0]  O_ASYNC_OUT,
    output wire [1:0]  O_SYNC_OUT,
    output wire [1:0]  O_OUTPUT_STATE,
    output wire [1:0]  O_RISING_EDGE_FLAG,
    output wire [1:0]  O_FALLING_EDGE_FLAG,
    output wire [1:0]  O_IRQ,
    output wire        O_RESET_REQ,
    output wire        O_COUNTER_ARRAY_KILL
);

    // hold channel is a foreign signal: three stages, change once 2 and 3 agree
    reg hc1_q;
    reg hc2_q;
    reg hc3_q;
    reg hc_q;
    always @(posedge I_CLK) begin
        if (I_RST) begin
            hc1_q <= 1'b1;
            hc2_q <= 1'b1;
            hc3_q <= 1'b1;
            hc_q  <= 1'b1;
        end else begin
            hc1_q <= I_HOLD_CONTROL_CHANNEL;
            hc2_q <= hc1_q;
            hc3_q <= hc2_q;
            if (hc2_q == hc3_q) begin
                hc_q <= hc3_q;
            end
        end
    end

    // ****************************************************************
    // comparator channels
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_cmp
            cmp_channel #(
                .LAST_PIN (g == 0 ? `CMP0_LAST_PIN : `CMP1_LAST_PIN)
            ) u_cmp (
                .i_clk           (I_CLK),
                .i_rst           (I_RST),
                .i_raw           (I_RAW[g]),
                .i_enable        (I_CMP_ENABLE[g]),
                .i_invert        (I_OUTPUT_INVERT[g]),
                .i_hold_en       (I_OUTPUT_HOLD_ENABLE[g]),
                .i_hold_ch       (hc_q),
                .i_rise_clr      (I_RISING_FLAG_CLR[g]),
                .i_fall_clr      (I_FALLING_FLAG_CLR[g]),
                .i_rise_mask     (I_RISING_IRQ_MASK[g]),
                .i_fall_mask     (I_FALLING_IRQ_MASK[g]),
                .i_input_config  (I_INPUT_CONFIG[2*g+1:2*g]),
                .i_pos_sel       (I_POS_CHANNEL_SELECT[4*g+3:4*g]),
                .i_neg_sel       (I_NEG_CHANNEL_SELECT[4*g+3:4*g]),
                .i_response      (I_RESPONSE_SELECT[2*g+1:2*g]),
                .i_pos_hyst      (I_POS_HYSTERESIS_SELECT[2*g+1:2*g]),
                .i_neg_hyst      (I_NEG_HYSTERESIS_SELECT[2*g+1:2*g]),
                .i_dac_level     (I_DAC_LEVEL[6*g+5:6*g]),
                .o_pos_route     (O_POS_ROUTE[3*g+2:3*g]),
                .o_neg_route     (O_NEG_ROUTE[3*g+2:3*g]),
                .o_pos_pin       (O_POS_PIN[4*g+3:4*g]),
                .o_neg_pin       (O_NEG_PIN[4*g+3:4*g]),
                .o_dac_ref_route (O_DAC_REF_ROUTE[3*g+2:3*g]),
                .o_dac_ref_pin   (O_DAC_REF_PIN[4*g+3:4*g]),
                .o_dac_level     (O_DAC_LEVEL[6*g+5:6*g]),
                .o_dac_on        (O_DAC_ON[g]),
                .o_power         (O_POWER[g]),
                .o_response      (O_RESPONSE[2*g+1:2*g]),
                .o_pos_hyst      (O_POS_HYST[2*g+1:2*g]),
                .o_neg_hyst      (O_NEG_HYST[2*g+1:2*g]),
                .o_async         (O_ASYNC_OUT[g]),
                .o_sync          (O_SYNC_OUT[g]),
                .o_state         (O_OUTPUT_STATE[g]),
                .o_rise_flag     (O_RISING_EDGE_FLAG[g]),
                .o_fall_flag     (O_FALLING_EDGE_FLAG[g]),
                .o_irq           (O_IRQ[g])
            );
        end
    endgenerate

    // ****************************************************************
    // comparator 0 system uses
    // ****************************************************************
    // synchronised state is used so reset and kill see no metastable level
    assign O_RESET_REQ          = O_SYNC_OUT[0];
    assign O_COUNTER_ARRAY_KILL = O_SYNC_OUT[0];

endmodule

// *** sim/cmp_analog_model.sv ***
// Purpose: far-side model of two analog comparator cores and one counter-array channel
// Assumes: the bench commands the analog outcome and the channel level
// Notes:   a core without power gives a level that changes every cycle
`timescale 1ns/1ps
module cmp_analog_model (
    input  wire       i_clk,
    input  wire [1:0] i_power,
    input  wire [1:0] i_pos_above,
    input  wire       i_chan_low,
    output wire [1:0] o_raw,
    output wire       o_chan
);
    // ****************************************
    // analog result
    // ****************************************
    reg [1:0] junk_q = 2'h1;
    always @(posedge i_clk) begin
        junk_q <= ~junk_q;
    end
    // an unpowered core has no defined result, so never offer a steady one
    assign o_raw  = (i_power & i_pos_above) | (~i_power & junk_q);
    assign o_chan = ~i_chan_low;
endmodule

// *** sim/analog_comparator_control_asserts.sv ***
// Purpose: concurrent checks on the comparator control ports
// Assumes: one clock, synchronous active-high reset
// Notes:   acceptance needs two equal synchroniser samples, hence depths 3 and 4
`timescale 1ns/1ps
module analog_comparator_control_asserts (
    input wire        I_CLK,
    input wire        I_RST,
    input wire [1:0]  I_CMP_ENABLE,
    input wire [1:0]  I_RISING_FLAG_CLR,
    input wire [1:0]  I_RISING_IRQ_MASK,
    input wire [1:0]  I_FALLING_IRQ_MASK,
    input wire [11:0] I_DAC_LEVEL,
    input wire [11:0] O_DAC_LEVEL,
    input wire [1:0]  O_POWER,
    input wire [1:0]  O_ASYNC_OUT,
    input wire [1:0]  O_SYNC_OUT,
    input wire [1:0]  O_OUTPUT_STATE,
    input wire [1:0]  O_RISING_EDGE_FLAG,
    input wire [1:0]  O_FALLING_EDGE_FLAG,
    input wire [1:0]  O_IRQ,
    input wire        O_RESET_REQ,
    input wire        O_COUNTER_ARRAY_KILL
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // ****************************************
    // sequences and checks
    // ****************************************
    sequence rise_seen; $rose(O_OUTPUT_STATE[0]); endsequence
    sequence fall_seen; $fell(O_OUTPUT_STATE[0]); endsequence
    sequence settled_high; $past(O_ASYNC_OUT[0], 3) && $past(O_ASYNC_OUT[0], 4); endsequence
    a_rise_sets: assert property (rise_seen |-> O_RISING_EDGE_FLAG[0])
        else $error("rising flag not set");
    a_fall_sets: assert property (fall_seen |-> O_FALLING_EDGE_FLAG[0])
        else $error("falling flag not set");
    a_rise_settled: assert property (rise_seen |-> settled_high)
        else $error("state rose without two settled samples");
    a_state_follows: assert property ($changed(O_OUTPUT_STATE[1]) |->
        O_OUTPUT_STATE[1] == $past(O_ASYNC_OUT[1], 3)) else $error("state change unsupported");
    a_flag_sticky: assert property (O_RISING_EDGE_FLAG[0] && !I_RISING_FLAG_CLR[0] |=>
        O_RISING_EDGE_FLAG[0]) else $error("rising flag dropped without clear");
    a_irq_level: assert property (O_IRQ == ((O_RISING_EDGE_FLAG & I_RISING_IRQ_MASK) |
        (O_FALLING_EDGE_FLAG & I_FALLING_IRQ_MASK))) else $error("irq mismatch");
    a_async_off: assert property (!I_CMP_ENABLE[1] |-> !O_ASYNC_OUT[1])
        else $error("disabled output not low");
    a_power_copy: assert property (!$past(I_RST) |-> O_POWER == $past(I_CMP_ENABLE))
        else $error("power does not follow enable");
    a_dac_copy: assert property (!$past(I_RST) |-> O_DAC_LEVEL == $past(I_DAC_LEVEL))
        else $error("dac level not passed on");
    a_sync_routes: assert property (O_SYNC_OUT == O_OUTPUT_STATE && O_RESET_REQ ==
        O_SYNC_OUT[0] && O_COUNTER_ARRAY_KILL == O_SYNC_OUT[0]) else $error("sync routing");
endmodule
bind analog_comparator_control analog_comparator_control_asserts u_analog_comparator_control_asserts (.*);

// *** sim/analog_comparator_control_tb.sv ***
// Purpose: self-checking bench for the comparator control block
// Assumes: the partner model supplies the analog results and the hold channel
// Notes:   expectations come from a small model kept in this bench
`timescale 1ns/1ps
module analog_comparator_control_tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [1:0]  en = 2'h0, inv = 2'h0, hen = 2'h0, above = 2'h0, nact, ren;
    reg  [1:0]  rclr = 2'h0, fclr = 2'h0, rmask = 2'h0, fmask = 2'h0;
    reg         chan_low = 1'b0;
    reg  [3:0]  cfg = 4'h0, resp = 4'h0, phys = 4'h0, nhys = 4'h0;
    reg  [7:0]  psel = 8'h00, nsel = 8'h00;
    reg  [11:0] dac = 12'h000;
    reg  [1:0]  m_state = 2'h0, m_rf = 2'h0, m_ff = 2'h0, m_hv = 2'h0, m_act = 2'h0;
    reg  [31:0] r;
    reg  [12:0] gt, ex;
    integer     mismatches = 0, comparisons = 0, it, g;
    wire [1:0]  raw, dac_on, power, async_o, sync_o, state_o, rflag, fflag, irq;
    wire        chan, rst_req, kill;
    wire [5:0]  pos_route, neg_route, ref_route;
    wire [7:0]  pos_pin, neg_pin, ref_pin;
    wire [11:0] dac_lvl;
    wire [3:0]  resp_o, phys_o, nhys_o;
    always #50 clk = ~clk;
    cmp_analog_model u_cmp_analog_model (.i_clk(clk), .i_power(power), .i_pos_above(above),
        .i_chan_low(chan_low), .o_raw(raw), .o_chan(chan));
    analog_comparator_control u_analog_comparator_control (
        .I_CLK(clk), .I_RST(rst), .I_RAW(raw), .I_CMP_ENABLE(en), .I_OUTPUT_INVERT(inv),
        .I_OUTPUT_HOLD_ENABLE(hen), .I_HOLD_CONTROL_CHANNEL(chan),
        .I_RISING_FLAG_CLR(rclr), .I_FALLING_FLAG_CLR(fclr),
        .I_RISING_IRQ_MASK(rmask), .I_FALLING_IRQ_MASK(fmask), .I_INPUT_CONFIG(cfg),
        .I_POS_CHANNEL_SELECT(psel), .I_NEG_CHANNEL_SELECT(nsel), .I_RESPONSE_SELECT(resp),
        .I_POS_HYSTERESIS_SELECT(phys), .I_NEG_HYSTERESIS_SELECT(nhys), .I_DAC_LEVEL(dac),
        .O_POS_ROUTE(pos_route), .O_NEG_ROUTE(neg_route), .O_POS_PIN(pos_pin),
        .O_NEG_PIN(neg_pin), .O_DAC_REF_ROUTE(ref_route), .O_DAC_REF_PIN(ref_pin),
        .O_DAC_LEVEL(dac_lvl), .O_DAC_ON(dac_on), .O_POWER(power), .O_RESPONSE(resp_o),
        .O_POS_HYST(phys_o), .O_NEG_HYST(nhys_o), .O_ASYNC_OUT(async_o),
        .O_SYNC_OUT(sync_o), .O_OUTPUT_STATE(state_o), .O_RISING_EDGE_FLAG(rflag),
        .O_FALLING_EDGE_FLAG(fflag), .O_IRQ(irq), .O_RESET_REQ(rst_req),
        .O_COUNTER_ARRAY_KILL(kill));
    // ****************************************
    // model and helpers
    // ****************************************
    function [2:0] rt(input [3:0] s, input gi, input p);
        if (s == 4'h8) rt = p ? 3'h2 : 3'h3;
        else if (s == 4'hf) rt = 3'h4;
        else if (s <= (gi ? 4'hc : 4'ha)) rt = 3'h1;
        else rt = 3'h0;
    endfunction
    function [12:0] rts(input gi, input [1:0] f, input [3:0] ps, input [3:0] ns);
        rts = {f == 2'h2 ? 3'h5 : rt(ps, gi, 1'b1),
               f == 2'h1 ? 3'h3 : (f == 2'h3 ? 3'h5 : rt(ns, gi, 1'b0)),
               f == 2'h2 ? rt(ps, gi, 1'b1) : (f == 2'h3 ? rt(ns, gi, 1'b0) : 3'h0),
               f == 2'h2 ? ps : (f == 2'h3 ? ns : 4'h0)};
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // a hold release takes four edges through the channel synchroniser and
    // four more through the result synchroniser; ten leaves margin
    task settle;
        reg [1:0] nx;
        begin
            repeat (10) @(posedge clk);
            nx = en & ((m_act & m_hv) | (~m_act & (above ^ inv)));
            m_rf = m_rf | (nx & ~m_state);
            m_ff = m_ff | (~nx & m_state);
            m_state = nx;
            chk({state_o, sync_o, async_o, rst_req, kill}, {{3{nx}}, {2{nx[0]}}});
            chk({rflag, fflag, irq}, {m_rf, m_ff, (m_rf & rmask) | (m_ff & fmask)});
            chk(power, en);
        end
    endtask
    task final_report;
        begin
            $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #5000000;
        mismatches = mismatches + 1;
        final_report;
    end
    initial begin
        r = $urandom(50914);
        repeat (2) @(posedge clk);
        chk({pos_pin, neg_pin}, 16'hffff);
        chk({resp_o, power, state_o, rflag, fflag}, 16'h0a00);
        rst <= 1'b0;
        en <= 2'h3;
        for (it = 0; it < 64; it = it + 1) begin
            r = $urandom;
            @(posedge clk);
            cfg <= {2{it[1:0]}};
            psel <= {~it[5:2], it[5:2]};
            nsel <= {it[5:2], ~it[5:2]};
            {resp, phys, nhys, dac} <= r[23:0];
            repeat (2) @(posedge clk);
            for (g = 0; g < 2; g = g + 1) begin
                gt = {pos_route[g*3+:3], neg_route[g*3+:3], ref_route[g*3+:3], ref_pin[g*4+:4]};
                ex = rts(g[0], cfg[g*2+:2], psel[g*4+:4], nsel[g*4+:4]);
                chk(gt, ex);
            end
            chk({pos_pin, neg_pin}, {psel, nsel});
            chk(dac_lvl, dac);
            chk({dac_on, resp_o, phys_o, nhys_o}, {cfg[3], cfg[1], resp, phys, nhys});
        end
        $display("routing test done");
        for (it = 0; it < 120; it = it + 1) begin
            r = $urandom;
            nact = r[1:0] & en & {2{r[2]}};
            m_hv = (nact & ~m_act & (above ^ inv)) | (m_hv & ~(nact & ~m_act));
            m_act = nact;
            @(posedge clk);
            hen <= r[1:0] & en;
            chan_low <= r[2];
            settle;
            ren = ((r[13:12] | r[15:14]) & ~en) | {2{r[16]}};
            @(posedge clk);
            {fmask, rmask, inv, above} <= r[11:4];
            en <= r[13:12] | r[15:14];
            settle;
            if (ren != 2'h0) begin
                // edges seen around power-on may be false, so software wipes them
                @(posedge clk);
                rclr <= ren;
                fclr <= ren;
                @(posedge clk);
                rclr <= 2'h0;
                fclr <= 2'h0;
                m_rf = m_rf & ~ren;
                m_ff = m_ff & ~ren;
                @(posedge clk);
                chk({rflag, fflag, irq}, {m_rf, m_ff, (m_rf & rmask) | (m_ff & fmask)});
            end
        end
        $display("edge and hold test done");
        final_report;
    end
endmodule
